// ==== shared/pasr_pkg.sv ====
package pasr_pkg;
    // Register indexes; each register is one aligned word at four times its index
    localparam logic [5:0] PASR_IDX_SUMMARY = 6'h32;
    localparam logic [5:0] PASR_IDX_PWR_INT = 6'h34;
    localparam logic [5:0] PASR_IDX_AUX_TWO = 6'h36;
    localparam logic [5:0] PASR_IDX_TENBASE = 6'h38;
    localparam logic [5:0] PASR_IDX_NEGRES = 6'h3C;
    localparam logic [5:0] PASR_IDX_TEST = 6'h3E;

    // Byte addresses of the register words on the AXI4-Lite slave
    localparam logic [7:0] PASR_OFF_SUMMARY = {PASR_IDX_SUMMARY, 2'h0};
    localparam logic [7:0] PASR_OFF_PWR_INT = {PASR_IDX_PWR_INT, 2'h0};
    localparam logic [7:0] PASR_OFF_AUX_TWO = {PASR_IDX_AUX_TWO, 2'h0};
    localparam logic [7:0] PASR_OFF_TENBASE = {PASR_IDX_TENBASE, 2'h0};
    localparam logic [7:0] PASR_OFF_NEGRES = {PASR_IDX_NEGRES, 2'h0};
    localparam logic [7:0] PASR_OFF_TEST = {PASR_IDX_TEST, 2'h0};
    localparam int PASR_ADDR_W = 8;

    // Summary status fields
    localparam int SUM_LINK = 2;
    localparam int SUM_AN_EN = 1;
    localparam int SUM_FDX = 0;
    localparam int SUM_SPEED = 3;
    localparam int SUM_AN_DONE = 15;

    // Power-detection interrupt fields
    localparam int PWR_MASK = 12;
    localparam int PWR_FLAG = 5;
    localparam logic [2:0] PWR_TOP_PATTERN = 3'h4;
    localparam logic [5:0] PWR_MID_PATTERN = 6'h1C;

    // 10BASE-T error and status fields
    localparam int TB_XSTAT = 13;
    localparam int TB_FORCE = 12;
    localparam int TB_AUTO_DIS = 11;
    localparam int TB_MANCH = 10;
    localparam int TB_EOF = 9;
    localparam int TB_SPEED = 1;
    localparam int TB_FDX = 0;
    localparam logic [2:0] TB_RSVD_RESET = 3'h1;
    localparam int TB_RSVD_LO = 5;

    // Negotiation result and control fields
    localparam int NR_RESULT_LO = 11;
    localparam int NR_RESTART = 8;
    localparam int NR_DONE = 7;
    localparam int NR_ACK_DONE = 6;
    localparam int NR_ACK_DET = 5;
    localparam int NR_ABILITY = 4;
    localparam int NR_ISOLATE = 3;

    // Test register field
    localparam int TS_SHADOW = 7;

    localparam logic [1:0] PASR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PASR_RESP_SLVERR = 2'h2;
endpackage

// ==== src/pasr_regs.sv ====
// Contract
// - Summary bit 2 is link state, latched low until the register is read.
// - Summary bit 1 reports auto-negotiation enabled, read-only, reset value 1.
// - Power interrupt: mask bit 12 resets 1 and blocks interrupt; bit 5 latched high.
// - Power interrupt register reachable only while shadow enable is set.
// - Bit 12 forces crossed mapping; else automatic unless disabled; bit 13 reports it.
// - Bit 11 disables automatic crossover when 1; resets to 0.
// - Bit 10 sets on a Manchester code error in 10BASE-T reception.
// - Bit 9 sets on an end-of-frame error in 10BASE-T reception.
// - Error bits are read-only, latched high until read or reset.
// - Each such error also drives the receive-error output high one clock cycle later.
// - Bits 15..11 flag the five negotiated results in documented order.
// - Writing 1 to bit 8 restarts negotiation, self-clearing; writing 0 does nothing.
// - Bit 7 reads 1 once auto-negotiation has completed.
// - Bits 6,5,4 report ack complete, ack detected, waiting for partner ability.
// - Bit 3 selects super-isolate mode when 1; resets to 0.
// - Test bit 7 enables shadow registers, reset 0; other bits never written.
// - Summary bits other than link bit 2 are copies of their source status bits.
//
// The AXI4-Lite slave port was chosen for this implementation.
module pasr_regs
    import pasr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PASR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [PASR_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic speed_fast,
    input wire logic an_enabled,
    input wire logic an_complete,
    input wire logic an_ack_complete,
    input wire logic an_ack_detected,
    input wire logic an_ability_wait,
    input wire logic [4:0] an_result,
    input wire logic crossed_pair_detect,
    input wire logic manchester_error,
    input wire logic eof_error,
    input wire logic power_device_detect,
    output logic crossed_pair_mapping,
    output logic auto_crossover_enable,
    output logic an_restart,
    output logic super_isolate,
    output logic power_detect_irq,
    output logic rx_error
);
    logic aw_held_reg;
    logic [PASR_ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [1:0] w_strb_reg;
    logic rd_pend_reg;
    logic [PASR_ADDR_W-1:0] ar_addr_reg;
    logic link_latch_reg;
    logic pwr_mask_reg;
    logic pwr_flag_reg;
    logic force_cross_reg;
    logic auto_dis_reg;
    logic manch_reg;
    logic eof_reg;
    logic restart_reg;
    logic isolate_reg;
    logic shadow_reg;
    logic do_write;
    logic do_read;
    logic wr_lo;
    logic wr_hi;
    logic rd_sum;
    logic rd_pwr;
    logic rd_tb;
    logic rd_known;
    logic [15:0] rd_word;
    logic cross_in_use;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_lo = do_write && w_strb_reg[0];
    assign wr_hi = do_write && w_strb_reg[1];
    assign do_read = rd_pend_reg && !s_axi_rvalid;
    assign rd_sum = do_read && ar_addr_reg == PASR_OFF_SUMMARY;
    assign rd_pwr = do_read && ar_addr_reg == PASR_OFF_PWR_INT && shadow_reg;
    assign rd_tb = do_read && ar_addr_reg == PASR_OFF_TENBASE;
    assign cross_in_use = force_cross_reg || (!auto_dis_reg && crossed_pair_detect);

    // Write address and data are taken independently, one write in flight
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[PASR_ADDR_W-1:2], 2'h0};
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb[1:0];
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PASR_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr_reg)
                PASR_OFF_SUMMARY, PASR_OFF_TENBASE, PASR_OFF_NEGRES, PASR_OFF_TEST:
                    s_axi_bresp <= PASR_RESP_OKAY;
                PASR_OFF_PWR_INT:
                    s_axi_bresp <= shadow_reg ? PASR_RESP_OKAY : PASR_RESP_SLVERR;
                default:
                    s_axi_bresp <= PASR_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_pend_reg <= 1'b0;
            ar_addr_reg <= '0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            s_axi_arready <= !rd_pend_reg && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                rd_pend_reg <= 1'b1;
                ar_addr_reg <= {s_axi_araddr[PASR_ADDR_W-1:2], 2'h0};
            end
            else if (do_read)
                rd_pend_reg <= 1'b0;
        end
    end

    always_comb
    begin
        rd_word = '0;
        rd_known = 1'b1;
        unique case (ar_addr_reg)
            PASR_OFF_SUMMARY:
            begin
                rd_word[SUM_AN_DONE] = an_complete;
                rd_word[SUM_SPEED] = speed_fast;
                rd_word[SUM_LINK] = link_latch_reg && link_up;
                rd_word[SUM_AN_EN] = an_enabled;
                rd_word[SUM_FDX] = full_duplex;
            end
            PASR_OFF_PWR_INT:
            begin
                rd_known = shadow_reg;
                rd_word[PWR_MASK] = pwr_mask_reg;
                rd_word[PWR_FLAG] = pwr_flag_reg;
                rd_word[15:13] = PWR_TOP_PATTERN;
                rd_word[11:6] = PWR_MID_PATTERN;
            end
            PASR_OFF_TENBASE:
            begin
                rd_word[TB_XSTAT] = cross_in_use;
                rd_word[TB_FORCE] = force_cross_reg;
                rd_word[TB_AUTO_DIS] = auto_dis_reg;
                rd_word[TB_MANCH] = manch_reg;
                rd_word[TB_EOF] = eof_reg;
                rd_word[TB_RSVD_LO+2:TB_RSVD_LO] = TB_RSVD_RESET;
                rd_word[TB_SPEED] = speed_fast;
                rd_word[TB_FDX] = full_duplex;
            end
            PASR_OFF_NEGRES:
            begin
                rd_word[NR_RESULT_LO+4:NR_RESULT_LO] = an_result;
                rd_word[NR_RESTART] = restart_reg;
                rd_word[NR_DONE] = an_complete;
                rd_word[NR_ACK_DONE] = an_ack_complete;
                rd_word[NR_ACK_DET] = an_ack_detected;
                rd_word[NR_ABILITY] = an_ability_wait;
                rd_word[NR_ISOLATE] = isolate_reg;
            end
            PASR_OFF_TEST:
                rd_word[TS_SHADOW] = shadow_reg;
            PASR_OFF_AUX_TWO:
                rd_word = '0;
            default:
                rd_known = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= PASR_RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_known ? rd_word : 16'h0000};
            s_axi_rresp <= rd_known ? PASR_RESP_OKAY : PASR_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Link latched low: a fail holds until read, an event beats the read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            link_latch_reg <= 1'b0;
        else if (!link_up)
            link_latch_reg <= 1'b0;
        else if (rd_sum)
            link_latch_reg <= 1'b1;
    end

    // Power-detection mask and latched flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_mask_reg <= 1'b1;
            pwr_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_hi && aw_addr_reg == PASR_OFF_PWR_INT && shadow_reg)
                pwr_mask_reg <= w_data_reg[PWR_MASK];
            if (power_device_detect)
                pwr_flag_reg <= 1'b1;
            else if (rd_pwr)
                pwr_flag_reg <= 1'b0;
        end
    end

    // Crossover controls and latched 10BASE-T errors
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            force_cross_reg <= 1'b0;
            auto_dis_reg <= 1'b0;
        end
        else if (wr_hi && aw_addr_reg == PASR_OFF_TENBASE)
        begin
            force_cross_reg <= w_data_reg[TB_FORCE];
            auto_dis_reg <= w_data_reg[TB_AUTO_DIS];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            manch_reg <= 1'b0;
            eof_reg <= 1'b0;
        end
        else
        begin
            if (manchester_error)
                manch_reg <= 1'b1;
            else if (rd_tb)
                manch_reg <= 1'b0;
            if (eof_error)
                eof_reg <= 1'b1;
            else if (rd_tb)
                eof_reg <= 1'b0;
        end
    end

    // Negotiation restart pulse and isolate control
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            restart_reg <= 1'b0;
            isolate_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= wr_hi && aw_addr_reg == PASR_OFF_NEGRES
                && w_data_reg[NR_RESTART];
            if (wr_lo && aw_addr_reg == PASR_OFF_NEGRES)
                isolate_reg <= w_data_reg[NR_ISOLATE];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shadow_reg <= 1'b0;
        else if (wr_lo && aw_addr_reg == PASR_OFF_TEST)
            shadow_reg <= w_data_reg[TS_SHADOW];
    end

    // Outputs registered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            crossed_pair_mapping <= 1'b0;
            auto_crossover_enable <= 1'b1;
            an_restart <= 1'b0;
            super_isolate <= 1'b0;
            power_detect_irq <= 1'b0;
            rx_error <= 1'b0;
        end
        else
        begin
            crossed_pair_mapping <= cross_in_use;
            auto_crossover_enable <= !auto_dis_reg;
            an_restart <= restart_reg;
            super_isolate <= isolate_reg;
            power_detect_irq <= pwr_flag_reg && !pwr_mask_reg;
            rx_error <= manchester_error || eof_error;
        end
    end
endmodule

// ==== verification/pasr_regs_monitor.sv ====
module pasr_regs_monitor
    import pasr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [PASR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic [4:0] an_result,
    input wire logic crossed_pair_detect,
    input wire logic manchester_error,
    input wire logic eof_error,
    input wire logic crossed_pair_mapping,
    input wire logic auto_crossover_enable,
    input wire logic an_restart,
    input wire logic rx_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PASR_ADDR_W-1:0] rd_addr_reg;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Remembers which word the pending read answer belongs to
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_reg <= s_axi_araddr;
    end

    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence neg_read;
        $rose(s_axi_rvalid) && rd_addr_reg == PASR_OFF_NEGRES;
    endsequence
    sequence ten_read;
        $rose(s_axi_rvalid) && rd_addr_reg == PASR_OFF_TENBASE;
    endsequence

    read_latency_a: assert property (ar_taken |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    refuse_data_a: assert property ($rose(s_axi_rvalid) && s_axi_rresp == PASR_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read returned data");
    result_map_a: assert property (neg_read |-> s_axi_rdata[15:11] == $past(an_result))
        else $error("negotiated result bits wrong");
    restart_read_a: assert property (neg_read |-> s_axi_rdata[10:8] == 3'h0)
        else $error("restart bit not self clearing");
    ten_fixed_a: assert property (ten_read |-> s_axi_rdata[7:5] == 3'h1)
        else $error("reserved field lost its value");
    xover_read_a: assert property (ten_read |-> s_axi_rdata[13] == crossed_pair_mapping)
        else $error("crossed mapping status wrong");
    rx_err_a: assert property ((manchester_error || eof_error) |=> rx_error)
        else $error("receive error not raised");
    rx_quiet_a: assert property (!(manchester_error || eof_error) |=> !rx_error)
        else $error("receive error without cause");
    xover_auto_a: assert property ((auto_crossover_enable && crossed_pair_detect) [*2]
        |-> crossed_pair_mapping) else $error("automatic crossover not applied");
    restart_pulse_a: assert property (an_restart |=> !an_restart)
        else $error("restart pulse too long");
    restart_cause_a: assert property ($rose(an_restart) |-> $past(s_axi_bvalid)
        || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("restart without write");
endmodule

bind pasr_regs pasr_regs_monitor u_monitor (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .an_result, .crossed_pair_detect,
    .manchester_error, .eof_error, .crossed_pair_mapping, .auto_crossover_enable,
    .an_restart, .rx_error
);

// ==== verification/pasr_regs_bench.sv ====
module pasr_regs_bench
    import pasr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, link_up = 1'h1, an_enabled = 1'h1;
    logic full_duplex = 1'h0, speed_fast = 1'h0, an_complete = 1'h0, an_ack_complete = 1'h0;
    logic an_ack_detected = 1'h0, an_ability_wait = 1'h0, crossed_pair_detect = 1'h0;
    logic manchester_error = 1'h0, eof_error = 1'h0, power_device_detect = 1'h0;
    logic [4:0] an_result = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic crossed_pair_mapping, auto_crossover_enable, an_restart, super_isolate;
    logic power_detect_irq, rx_error;
    logic [15:0] rv, sv;
    int seed = 32'hDA5A;
    int n_mismatch = 0, tests_run = 0, n_rst = 0;

    pasr_regs dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .link_up, .full_duplex, .speed_fast, .an_enabled, .an_complete, .an_ack_complete,
        .an_ack_detected, .an_ability_wait, .an_result, .crossed_pair_detect,
        .manchester_error, .eof_error, .power_device_detect, .crossed_pair_mapping,
        .auto_crossover_enable, .an_restart, .super_isolate, .power_detect_irq, .rx_error
    );

    always #5 aclk = ~aclk;
    always @(posedge aclk) if (an_restart === 1'h1) n_rst++;

    task automatic close_out;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'($random(seed)), d};
        s_axi_wstrb <= {2'($random(seed)), 2'h3};
        s_axi_awprot <= 3'($random(seed));
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
        input logic [1:0] er = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= 3'($random(seed));
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        rv = s_axi_rdata[15:0];
        chk(rv & m, e);
        chk(s_axi_rresp, er);
    endtask

    // One-cycle event: 0 code error, 1 frame-end error, 2 powered device found
    task automatic ev(input int k);
        @(posedge aclk);
        {power_device_detect, eof_error, manchester_error} <= 3'(1 << k);
        @(posedge aclk);
        {power_device_detect, eof_error, manchester_error} <= 3'h0;
    endtask

    function automatic logic [15:0] exp_ten(logic f, logic dis, logic [1:0] er);
        return {2'h0, f | (!dis & crossed_pair_detect), f, dis, er, 1'h0, 3'h1, 3'h0,
            speed_fast, full_duplex};
    endfunction

    function automatic logic [15:0] exp_neg(logic iso);
        return {an_result, 3'h0, an_complete, an_ack_complete, an_ack_detected,
            an_ability_wait, iso, 3'h0};
    endfunction

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        chk(auto_crossover_enable, 1'h1);
        chk(super_isolate, 1'h0);
        chk(power_detect_irq, 1'h0);
        rc(PASR_OFF_TEST, 16'h0000, 16'h0080);
        rc(PASR_OFF_SUMMARY, 16'h0002, 16'h0006);
        rc(PASR_OFF_SUMMARY, 16'h0006, 16'h0006);
        link_up <= 1'h0;
        @(posedge aclk);
        link_up <= 1'h1;
        rc(PASR_OFF_SUMMARY, 16'h0000, 16'h0004);
        rc(PASR_OFF_SUMMARY, 16'h0004, 16'h0004);
        repeat (6)
        begin
            {full_duplex, speed_fast, an_enabled, an_complete, an_ack_complete,
                an_ack_detected, an_ability_wait, an_result} <= 12'($random(seed));
            @(posedge aclk);
            rc(PASR_OFF_SUMMARY, {an_complete, 11'h0, speed_fast, 1'h0, an_enabled,
                full_duplex}, 16'h800B);
            rc(PASR_OFF_NEGRES, exp_neg(1'h0), 16'hFFFF);
        end
        crossed_pair_detect <= 1'h1;
        @(posedge aclk);
        rc(PASR_OFF_TENBASE, exp_ten(1'h0, 1'h0, 2'h0), 16'hFFFF);
        sv = rv;
        wr(PASR_OFF_TENBASE, sv | 16'h0800);
        repeat (2) @(posedge aclk);
        chk(auto_crossover_enable, 1'h0);
        chk(crossed_pair_mapping, 1'h0);
        wr(PASR_OFF_TENBASE, sv | 16'h1800);
        rc(PASR_OFF_TENBASE, exp_ten(1'h1, 1'h1, 2'h0), 16'hFFFF);
        chk(crossed_pair_mapping, 1'h1);
        wr(PASR_OFF_TENBASE, sv);
        crossed_pair_detect <= 1'h0;
        for (int k = 0; k < 2; k++)
        begin
            ev(k);
            #1;
            chk(rx_error, 1'h1);
            rc(PASR_OFF_TENBASE, exp_ten(1'h0, 1'h0, 2'(2 >> k)), 16'hFFFF);
            rc(PASR_OFF_TENBASE, exp_ten(1'h0, 1'h0, 2'h0), 16'hFFFF);
        end
        rc(PASR_OFF_PWR_INT, 16'h0000, 16'hFFFF, PASR_RESP_SLVERR);
        rc(PASR_OFF_TEST, 16'h0000, 16'h0080);
        sv = rv;
        wr(PASR_OFF_TEST, sv | 16'h0080);
        rc(PASR_OFF_PWR_INT, 16'h9700, 16'hFFFF);
        ev(2);
        repeat (3) @(posedge aclk);
        chk(power_detect_irq, 1'h0);
        rc(PASR_OFF_PWR_INT, 16'h9720, 16'hFFFF);
        rc(PASR_OFF_PWR_INT, 16'h9700, 16'hFFFF);
        wr(PASR_OFF_PWR_INT, 16'h8700);
        ev(2);
        repeat (3) @(posedge aclk);
        chk(power_detect_irq, 1'h1);
        rc(PASR_OFF_PWR_INT, 16'h8720, 16'hFFFF);
        repeat (3) @(posedge aclk);
        chk(power_detect_irq, 1'h0);
        wr(PASR_OFF_TEST, sv & 16'hFF7F);
        wr(PASR_OFF_PWR_INT, 16'h9700, PASR_RESP_SLVERR);
        wr(PASR_OFF_NEGRES, 16'h0008);
        repeat (2) @(posedge aclk);
        chk(super_isolate, 1'h1);
        rc(PASR_OFF_NEGRES, exp_neg(1'h1), 16'hFFFF);
        n_rst = 0;
        wr(PASR_OFF_NEGRES, 16'h0108);
        repeat (4) @(posedge aclk);
        chk(n_rst, 1);
        wr(PASR_OFF_NEGRES, 16'h0008);
        repeat (4) @(posedge aclk);
        chk(n_rst, 1);
        // Latched error and isolate control must not survive a reset in mid-run
        ev(0);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rc(PASR_OFF_TENBASE, exp_ten(1'h0, 1'h0, 2'h0), 16'hFFFF);
        chk(super_isolate, 1'h0);
        rc(PASR_OFF_AUX_TWO, 16'h0000, 16'hFFFF);
        rc(8'h40, 16'h0000, 16'hFFFF, PASR_RESP_SLVERR);
        close_out;
    end

    initial
    begin
        #40us;
        n_mismatch++;
        close_out;
    end
endmodule
